// ---- rtl/adc_pair_ctrl.v ----
// converter pair control: hard reset, restart, phase delay and ready timing
`include "adc_pair_defs.vh"

module adc_pair_ctrl #(
    parameter BASE_DIV = `MOD_CLK_BASE_DIV
) (
    input wire clk_in,
    input wire srst_in,
    input wire hard_rst_n_in,
    input wire [`OSR_SEL_W-1:0] osr_sel_in,
    input wire [`PRE_W-1:0] pre_sel_in,
    input wire link_lagging_in,
    input wire delay_wr_in,
    input wire [`DLY_W-1:0] delay_wdata_in,
    output wire [`DLY_W-1:0] delay_rdata_out,
    input wire [1:0] mod_bits_in,
    output wire [2*`CMP_W-1:0] cmp_force_pattern_out,
    output wire cmp_force_en_out,
    output wire modulator_clear_out,
    output wire modulator_sample_clock_out,
    output wire [`CODE_W-1:0] odd_code_out,
    output wire [`CODE_W-1:0] even_code_out,
    output wire odd_ready_out,
    output wire even_ready_out,
    output wire sample_ready_pin_n_out,
    output wire sample_ready_pin_oe_n_out,
    input wire sdo_data_in,
    input wire sdo_drive_in,
    output wire sdo_out,
    output wire sdo_oe_n_out
);
    // ------------------------------------------------------------------
    // reset and restart requests
    // ------------------------------------------------------------------
    wire in_hard_rst; // pin level, taken straight from the pad
    wire wr_accept; // a delay write that is allowed to land
    wire ratio_changed; // timing settings moved under the converters
    wire conv_hold; // converters held this cycle
    reg [`DLY_W-1:0] delay_q; // channel_pair_delay register
    reg [`OSR_SEL_W-1:0] osr_prev_q; // ratio seen at last cycle
    reg [`PRE_W-1:0] pre_prev_q; // prescaler seen at last cycle
    reg load_pend_q; // counters must be reloaded on release
    reg in_hard_rst_q; // registered copy for the comparator force
    wire tick; // modulator sample clock enable

    // the pin is looked at directly, not through the serial engine
    assign in_hard_rst = !hard_rst_n_in;

    // writes arriving while the pin is low are simply dropped
    assign wr_accept = delay_wr_in && !in_hard_rst;

    assign ratio_changed = (osr_sel_in != osr_prev_q)
                           || (pre_sel_in != pre_prev_q);

    // any accepted write restarts, even with an unchanged value
    assign conv_hold = srst_in || in_hard_rst || wr_accept
                       || ratio_changed;

    // delay register: default on either reset, else last accepted write
    always @(posedge clk_in) begin
        if (srst_in || in_hard_rst) begin
            delay_q <= `DLY_RESET;
        end else if (wr_accept) begin
            delay_q <= delay_wdata_in;
        end
    end

    // settings trackers and reload flag
    always @(posedge clk_in) begin
        if (srst_in) begin
            osr_prev_q <= `OSR_SEL_RESET;
            pre_prev_q <= {`PRE_W{1'b0}};
            load_pend_q <= 1'b1;
            in_hard_rst_q <= 1'b0;
        end else begin
            osr_prev_q <= osr_sel_in;
            pre_prev_q <= pre_sel_in;
            in_hard_rst_q <= in_hard_rst;
            // reload comes on the first cycle after the hold lifts
            if (conv_hold) begin
                load_pend_q <= 1'b1;
            end else begin
                load_pend_q <= 1'b0;
            end
        end
    end

    assign delay_rdata_out = delay_q;

    // modulator side: comparators forced and stored charge dumped
    assign cmp_force_en_out = in_hard_rst_q;
    assign cmp_force_pattern_out = {`CMP_RESET_PATTERN, `CMP_RESET_PATTERN};
    assign modulator_clear_out = in_hard_rst_q;

    // ------------------------------------------------------------------
    // modulator sample clock enable, shared by both channels
    // ------------------------------------------------------------------
    // one enable for both, so the two converters sample together
    sample_tick_gen #(
        .BASE_DIV(BASE_DIV)
    ) u_tick (
        .clk_in(clk_in),
        .restart_in(conv_hold || load_pend_q),
        .pre_sel_in(pre_sel_in),
        .tick_out(tick)
    );

    assign modulator_sample_clock_out = tick;

    // ------------------------------------------------------------------
    // delay folding and per-channel offsets
    // ------------------------------------------------------------------
    wire [`DLY_W-1:0] delay_fold; // delay seen at the active ratio
    wire [`CNT_W-1:0] delay_ext; // sign extended to counter width
    wire [`CNT_W-1:0] osr_val; // ratio in modulator periods
    wire [`CNT_W-1:0] osr_m1; // reload value of the window counter
    wire [`CNT_W-1:0] osr_half; // fixed reference point of odd channel
    wire [2*`CNT_W-1:0] offset_all; // first-ready offsets, odd low
    wire even_lags; // delay is zero or positive

    // only bits up to the active sign bit take part
    delay_sign_fold u_fold (
        .raw_in(delay_q),
        .osr_sel_in(osr_sel_in),
        .folded_out(delay_fold)
    );

    // two's complement, counts modulator periods
    assign delay_ext = {delay_fold[`DLY_W-1], delay_fold};
    assign osr_val = `OSR_MIN << osr_sel_in;
    assign osr_m1 = osr_val - 13'h0001;
    assign osr_half = `OSR_HALF_MIN << osr_sel_in;

    // the folded value always lies within minus half to half minus one,
    // so the even offset stays inside one ratio window
    assign offset_all[`CNT_W-1:0] = osr_half;
    assign offset_all[2*`CNT_W-1:`CNT_W] = osr_half + delay_ext;

    // positive delay starts the even window later: even lags
    assign even_lags = !delay_fold[`DLY_W-1];

    // ------------------------------------------------------------------
    // per-channel window counter, sinc accumulator and double buffer
    // channel 0 of the loop is the odd (reference) channel, 1 the even
    // ------------------------------------------------------------------
    wire [1:0] fire; // end of averaging window this tick
    wire [1:0] ready_pulse; // buffered result just published
    wire [2*`CODE_W-1:0] code_all; // published codes, odd low

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_chan
            reg [`CNT_W-1:0] cnt_q; // periods until the window closes
            reg [`CNT_W-1:0] acc_q; // ones counted in this window
            reg [`CNT_W-1:0] ones; // window total incl. this sample
            reg [`CNT_W-1:0] ones_sat; // clamped to stay in range
            reg signed [`CNT_W-1:0] diff; // centred result
            reg [`CODE_W-1:0] code_d; // left justified result
            reg [`CODE_W-1:0] hold_q; // first buffer stage
            reg [`CODE_W-1:0] out_q; // second buffer stage, seen outside
            reg fire1_q; // first stage holds a fresh result
            reg fire2_q; // second stage holds a fresh result

            assign fire[c] = tick && (cnt_q == {`CNT_W{1'b0}});

            // result of the closing window, scaled like the output tables
            always @* begin
                ones = acc_q + {{(`CNT_W-1){1'b0}}, mod_bits_in[c]};
                // a full-scale window would overflow the positive code
                if (ones >= osr_val) begin
                    ones_sat = osr_m1;
                end else begin
                    ones_sat = ones;
                end
                diff = ones_sat - osr_half;
                code_d = {{(`CODE_W-`CNT_W){diff[`CNT_W-1]}}, diff}
                         << (`JUST_SHIFT_MIN - {2'b00, osr_sel_in});
            end

            // window counter: loaded with the channel offset on release,
            // so only the averaging start differs between channels
            always @(posedge clk_in) begin
                if (conv_hold) begin
                    cnt_q <= {`CNT_W{1'b0}};
                end else if (load_pend_q) begin
                    cnt_q <= offset_all[c*`CNT_W +: `CNT_W];
                end else if (fire[c]) begin
                    cnt_q <= osr_m1;
                end else if (tick) begin
                    cnt_q <= cnt_q - 13'h0001;
                end
            end

            // accumulator: cleared on every hold, restarts each window
            always @(posedge clk_in) begin
                if (conv_hold || load_pend_q) begin
                    acc_q <= {`CNT_W{1'b0}};
                end else if (fire[c]) begin
                    acc_q <= {`CNT_W{1'b0}};
                end else if (tick) begin
                    acc_q <= ones;
                end
            end

            // double output buffer; both stages zero while held, so the
            // published code reads as zero during any reset
            always @(posedge clk_in) begin
                if (conv_hold) begin
                    hold_q <= {`CODE_W{1'b0}};
                    out_q <= {`CODE_W{1'b0}};
                    fire1_q <= 1'b0;
                    fire2_q <= 1'b0;
                end else begin
                    fire1_q <= fire[c];
                    fire2_q <= fire1_q;
                    if (fire[c]) begin
                        hold_q <= code_d;
                    end
                    if (fire1_q) begin
                        out_q <= hold_q;
                    end
                end
            end

            // both channels share the same pipeline depth, so the
            // spacing of their ready pulses equals the delay
            assign ready_pulse[c] = fire2_q;
            assign code_all[c*`CODE_W +: `CODE_W] = out_q;
        end
    endgenerate

    assign odd_code_out = code_all[`CODE_W-1:0];
    assign even_code_out = code_all[2*`CODE_W-1:`CODE_W];
    assign odd_ready_out = ready_pulse[0];
    assign even_ready_out = ready_pulse[1];

    // ------------------------------------------------------------------
    // sample ready pin
    // ------------------------------------------------------------------
    wire pin_event; // a pulse is due on the pin
    reg pin_low_q; // pin pulled low until the next modulator tick
    reg pin_arm_q; // pulse started, waiting for the next tick to end

    // linked: only the lagging channel; else both channels
    assign pin_event = link_lagging_in
                       ? (even_lags ? ready_pulse[1] : ready_pulse[0])
                       : (ready_pulse[0] || ready_pulse[1]);

    // defaults alone are enough to get pulses after power reset;
    // the first few are unsettled and the host is left to drop them
    always @(posedge clk_in) begin
        if (srst_in || in_hard_rst) begin
            pin_low_q <= 1'b0;
            pin_arm_q <= 1'b0;
        end else if (pin_event) begin
            pin_low_q <= 1'b1;
            pin_arm_q <= 1'b1;
        end else if (tick && pin_arm_q) begin
            // a tick may land in the same cycle as the event; the event
            // branch wins so the pulse runs on until the following tick
            pin_low_q <= 1'b0;
            pin_arm_q <= 1'b0;
        end
    end

    assign sample_ready_pin_n_out = !pin_low_q;

    // both output pins released straight from the pin level
    assign sample_ready_pin_oe_n_out = in_hard_rst;
    assign sdo_out = sdo_data_in && !in_hard_rst;
    assign sdo_oe_n_out = in_hard_rst || !sdo_drive_in;

endmodule

// ---- rtl/adc_pair_defs.vh ----
// shared constants for the converter pair control block
`ifndef ADC_PAIR_DEFS_VH
`define ADC_PAIR_DEFS_VH

// delay register: width and value after any reset
`define DLY_W 12
`define DLY_RESET 12'h000

// oversample ratio select: 3 bits, code 0 is ratio 32, code 7 is 4096
`define OSR_SEL_W 3
`define OSR_SEL_RESET 3'h3
// ratio 32 in counter width, half of it, and sign bit index at ratio 32
`define OSR_MIN 13'h0020
`define OSR_HALF_MIN 13'h0010
`define SIGN_BIT_MIN 4'h4

// counter, accumulator and code widths
`define CNT_W 13
`define CODE_W 24
// left justify shift at ratio 32; shrinks by one per doubling
`define JUST_SHIFT_MIN 5'h13

// prescaler select width and main clocks per modulator period at /1
`define PRE_W 2
`define MOD_CLK_BASE_DIV 4

// comparator pattern forced on every converter during hard reset
`define CMP_RESET_PATTERN 4'h3
`define CMP_W 4

`endif

// ---- rtl/sample_tick_gen.v ----
// modulator sample clock enable generator from the prescaled main clock
`include "adc_pair_defs.vh"

module sample_tick_gen #(
    parameter BASE_DIV = `MOD_CLK_BASE_DIV
) (
    input wire clk_in,
    input wire restart_in,
    input wire [`PRE_W-1:0] pre_sel_in,
    output wire tick_out
);
    // base divide held at counter width so the shift keeps its bits
    localparam [7:0] BASE_DIV8 = BASE_DIV;
    // period in main clocks: base divide times 1, 2, 4 or 8
    wire [7:0] period_m1;
    reg [7:0] div_q; // cycles since last tick
    reg [7:0] div_d;
    reg tick_q; // one-cycle enable pulse

    assign period_m1 = (BASE_DIV8 << pre_sel_in) - 8'h01;

    // next count: restart aligns the first tick to a full period
    always @* begin
        if (restart_in || div_q >= period_m1) begin
            div_d = 8'h00;
        end else begin
            div_d = div_q + 8'h01;
        end
    end

    // tick is registered so it never glitches on a prescaler change
    always @(posedge clk_in) begin
        div_q <= div_d;
        tick_q <= !restart_in && (div_q >= period_m1);
    end

    assign tick_out = tick_q;
endmodule

// ---- rtl/delay_sign_fold.v ----
// folds the delay register to the active ratio: sign extends from its bit
`include "adc_pair_defs.vh"

module delay_sign_fold (
    input wire [`DLY_W-1:0] raw_in,
    input wire [`OSR_SEL_W-1:0] osr_sel_in,
    output wire [`DLY_W-1:0] folded_out
);
    // sign bit sits four places above the ratio code
    wire [3:0] sign_idx;
    wire sign_bit;

    assign sign_idx = `SIGN_BIT_MIN + {1'b0, osr_sel_in};
    assign sign_bit = raw_in[sign_idx];

    // bits above the active sign bit are ignored and replaced by the sign
    genvar i;
    generate
        for (i = 0; i < `DLY_W; i = i + 1) begin : g_bit
            localparam [3:0] BIT_IDX = i;
            assign folded_out[i] = (BIT_IDX <= sign_idx) ? raw_in[i]
                                                         : sign_bit;
        end
    endgenerate
endmodule

// ---- verif/adc_pair_checker_assertions.sv ----
// concurrent checks on the converter pair control block ports
`include "adc_pair_defs.vh"
module adc_pair_checker #(
    parameter BASE_DIV = 4
) (
    input logic clk_in,
    input logic srst_in,
    input logic hard_rst_n_in,
    input logic delay_wr_in,
    input logic [`DLY_W-1:0] delay_wdata_in,
    input logic [`DLY_W-1:0] delay_rdata_out,
    input logic [2*`CMP_W-1:0] cmp_force_pattern_out,
    input logic cmp_force_en_out,
    input logic modulator_clear_out,
    input logic [`CODE_W-1:0] odd_code_out,
    input logic [`CODE_W-1:0] even_code_out,
    input logic odd_ready_out,
    input logic even_ready_out,
    input logic sample_ready_pin_oe_n_out,
    input logic sdo_oe_n_out
);
    default clocking chk_cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // accepted write, not cut short by a hard reset on the next edge
    sequence write_taken;
        delay_wr_in && hard_rst_n_in ##1 hard_rst_n_in;
    endsequence
    // no odd pulse for eight cycles: far shorter than any legal gap
    sequence odd_quiet;
        (!odd_ready_out) [*8];
    endsequence
    a_hard_zero_code: assert property (
        !$past(hard_rst_n_in) |-> odd_code_out == 0 && even_code_out == 0)
        else $error("codes not zero in hard reset");
    a_hard_force: assert property (
        !$past(hard_rst_n_in) |-> cmp_force_en_out && modulator_clear_out
        && cmp_force_pattern_out == 8'h33)
        else $error("comparators not forced in hard reset");
    a_hard_defaults: assert property (
        !$past(hard_rst_n_in) |-> delay_rdata_out == `DLY_RESET
        && !odd_ready_out && !even_ready_out)
        else $error("state kept through hard reset");
    a_hard_float: assert property (
        !hard_rst_n_in |-> sdo_oe_n_out && sample_ready_pin_oe_n_out)
        else $error("pins driven in hard reset");
    a_write_readback: assert property (
        write_taken |-> delay_rdata_out == $past(delay_wdata_in))
        else $error("delay register lost the write");
    a_write_restart: assert property (
        write_taken |-> odd_code_out == 0 && even_code_out == 0)
        else $error("write did not restart converters");
    a_restart_quiet: assert property (
        write_taken |=> odd_quiet)
        else $error("odd ready too soon after restart");
    a_odd_spacing: assert property (
        odd_ready_out |=> odd_quiet)
        else $error("odd ready pulses too close");
    a_even_spacing: assert property (
        even_ready_out |=> (!even_ready_out) [*8])
        else $error("even ready pulses too close");
endmodule

bind adc_pair_ctrl adc_pair_checker #(.BASE_DIV(BASE_DIV)) u_chk (
    .clk_in, .srst_in, .hard_rst_n_in, .delay_wr_in, .delay_wdata_in,
    .delay_rdata_out, .cmp_force_pattern_out, .cmp_force_en_out,
    .modulator_clear_out, .odd_code_out, .even_code_out, .odd_ready_out,
    .even_ready_out, .sample_ready_pin_oe_n_out, .sdo_oe_n_out
);

// ---- verif/host_model.sv ----
// host side: waits out settling, counts ready pin pulses, reads a word
module host_model (
    input wire logic clk_in,
    input wire logic pin_n_in,
    input wire logic pin_oe_n_in,
    output logic sdo_drive_out,
    output logic sdo_data_out,
    output int pulses_out
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SETTLE = 64; // short stand-in for the settling wait
    logic pin_q = 1'b1; // last pin level, floating reads as idle high
    int settle_q = 0; // driven cycles seen so far
    int left_q = 0; // bits left in the current read
    initial begin
        sdo_drive_out = 1'b0;
        sdo_data_out = 1'b0;
        pulses_out = 0;
    end
    // early pulses may carry unsettled data, so they are not counted
    always @(posedge clk_in) begin
        pin_q <= pin_n_in | pin_oe_n_in;
        settle_q <= pin_oe_n_in ? 0 : settle_q + 1;
        if (pin_q && !(pin_n_in | pin_oe_n_in) && settle_q > SETTLE) begin
            pulses_out <= pulses_out + 1;
            left_q <= 24;
        end else if (left_q > 0) begin
            left_q <= left_q - 1;
        end
        sdo_drive_out <= left_q > 1;
        sdo_data_out <= ~sdo_data_out; // never a stale level
    end
endmodule

// ---- verif/tb_adc_pair_ctrl.sv ----
// testbench for the converter pair control block
`include "adc_pair_defs.vh"
module tb_adc_pair_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BD = 1; // one main clock per tick keeps runs short
    typedef struct {
        logic [2:0] oversample_ratio;
        logic [1:0] pre;
        logic [11:0] wd;
        int d;
    } row_t;
    // ratio code, prescale, written delay, expected even-minus-odd ticks
    row_t rows[9] = '{'{3'h0, 2'h0, 12'h005, 5}, '{3'h0, 2'h0, 12'hff5, -11},
        '{3'h0, 2'h0, 12'h00f, 15}, '{3'h0, 2'h0, 12'h010, -16},
        '{3'h0, 2'h0, 12'h7f0, -16}, '{3'h0, 2'h1, 12'h003, 3},
        '{3'h1, 2'h0, 12'h030, -16}, '{3'h1, 2'h0, 12'h01f, 31},
        '{3'h1, 2'h0, 12'h01f, 31}};
    logic clk_in = 1'b0, srst_in = 1'b1, hard_rst_n_in = 1'b1;
    logic [2:0] osr_sel_in = 3'h0;
    logic [1:0] pre_sel_in = 2'h0, mod_bits_in = 2'h0;
    logic link_lagging_in = 1'b1, delay_wr_in = 1'b0;
    logic [11:0] delay_wdata_in = 12'h000;
    logic sdo_data_in, sdo_drive_in;
    wire [11:0] delay_rdata_out;
    wire [7:0] cmp_force_pattern_out;
    wire [23:0] odd_code_out, even_code_out;
    wire cmp_force_en_out, modulator_clear_out, modulator_sample_clock_out;
    wire odd_ready_out, even_ready_out, sample_ready_pin_n_out;
    wire sample_ready_pin_oe_n_out, sdo_out, sdo_oe_n_out;
    int mismatches = 0, n_compared = 0, pulses;
    int cyc = 0, t_o1 = -1, t_o2 = -1, t_e = -1; // first ready times

    adc_pair_ctrl #(.BASE_DIV(BD)) dut_u (.clk_in, .srst_in, .hard_rst_n_in,
        .osr_sel_in, .pre_sel_in, .link_lagging_in, .delay_wr_in,
        .delay_wdata_in, .delay_rdata_out, .mod_bits_in,
        .cmp_force_pattern_out, .cmp_force_en_out, .modulator_clear_out,
        .modulator_sample_clock_out, .odd_code_out, .even_code_out,
        .odd_ready_out, .even_ready_out, .sample_ready_pin_n_out,
        .sample_ready_pin_oe_n_out, .sdo_data_in, .sdo_drive_in, .sdo_out,
        .sdo_oe_n_out);
    host_model host_u (.clk_in, .pin_n_in(sample_ready_pin_n_out),
        .pin_oe_n_in(sample_ready_pin_oe_n_out), .sdo_drive_out(sdo_drive_in),
        .sdo_data_out(sdo_data_in), .pulses_out(pulses));

    initial begin
        forever #25 clk_in = ~clk_in;
    end
    // time stamps of the first two odd and the first even ready pulses
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        mod_bits_in <= mod_bits_in + 2'h1; // busy bitstream on both inputs
        if (odd_ready_out === 1'b1 && t_o1 < 0) t_o1 <= cyc;
        else if (odd_ready_out === 1'b1 && t_o2 < 0) t_o2 <= cyc;
        if (even_ready_out === 1'b1 && t_e < 0) t_e <= cyc;
    end

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // write strobe for one edge, then forget old time stamps
    task automatic write_dly(input logic [11:0] v);
        @(posedge clk_in);
        delay_wr_in <= 1'b1;
        delay_wdata_in <= v;
        @(posedge clk_in);
        delay_wr_in <= 1'b0;
        @(posedge clk_in);
        {t_o1, t_o2, t_e} = {-32'sd1, -32'sd1, -32'sd1};
    endtask
    // bounded wait for two odd pulses and one even pulse
    task automatic wait_meas();
        for (int i = 0; i < 600 && (t_o2 < 0 || t_e < 0); i++)
            @(posedge clk_in);
    endtask

    initial begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        {t_o1, t_o2, t_e} = {-32'sd1, -32'sd1, -32'sd1};
        chk_val(24'(delay_rdata_out), 24'h0);
        wait_meas();
        chk_val(24'(t_o2 - t_o1), 24'(32 * BD));
        chk_val(24'(t_e - t_o1), 24'h0);
        $display("default run done");
        foreach (rows[i]) begin
            osr_sel_in <= rows[i].oversample_ratio;
            pre_sel_in <= rows[i].pre;
            write_dly(rows[i].wd);
            chk_val(24'(delay_rdata_out), 24'(rows[i].wd));
            wait_meas();
            chk_val(24'(t_o2 - t_o1),
                24'((32 << rows[i].oversample_ratio) * (BD << rows[i].pre)));
            chk_val(24'(t_e - t_o1),
                24'(rows[i].d * (BD << rows[i].pre)));
            $display("row %0d done", i);
        end
        chk_val(24'(pulses > 0), 24'h1);
        hard_rst_n_in <= 1'b0;
        @(posedge clk_in);
        delay_wr_in <= 1'b1;
        delay_wdata_in <= 12'h0aa;
        #1 chk_val({sdo_out, sdo_oe_n_out,
            sample_ready_pin_oe_n_out}, 24'h3);
        @(posedge clk_in);
        delay_wr_in <= 1'b0;
        @(posedge clk_in);
        chk_val({cmp_force_en_out, modulator_clear_out,
            cmp_force_pattern_out}, 24'h333);
        chk_val(odd_code_out | even_code_out, 24'h0);
        chk_val(24'(delay_rdata_out), 24'h0);
        hard_rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk_val({cmp_force_en_out, sample_ready_pin_oe_n_out,
            delay_rdata_out}, 24'h0);
        $display("hard reset test done");
        give_verdict();
    end
    // watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        give_verdict();
    end
endmodule
